// ===== core/fpx_exception_status.sv
`timescale 1ns/10ps
module fpx_exception_status
	import fpx_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Datapath result in
	input wire logic op_valid,
	input wire fpx_op_t op,
	// Unloaded result and status
	output logic result_valid,
	output fpx_unload_t unload
);

	fpx_round_t round_mode;
	fpx_round_t next_round_mode;
	logic ieee_mode;
	logic next_ieee_mode;
	logic dp_write;
	logic next_dp_write;
	logic [31:0] next_hrdata;
	logic next_result_valid;
	fpx_unload_t next_unload;
	logic addr_take;
	logic [3:0] addr_low;
	logic overflow_flag;
	logic underflow_flag;
	logic inexact_flag;
	logic [31:0] plain_value;
	logic [31:0] signed_zero;

	// Zero wait states: every transfer completes in its first data phase
	assign hreadyout = 1'b1;
	assign hresp = FPX_HRESP_OKAY;
	assign addr_take = hsel && htrans[1] && hready;
	assign addr_low = haddr[3:0];

	always_comb
	begin
		next_round_mode = round_mode;
		next_ieee_mode = ieee_mode;
		next_dp_write = 1'b0;
		next_hrdata = hrdata;
		if (dp_write)
		begin
			next_round_mode = fpx_round_t'(hwdata[FPX_CTRL_ROUND_LSB +: 2]);
			next_ieee_mode = hwdata[FPX_CTRL_IEEE_BIT];
		end
		if (addr_take)
		begin
			// Only word writes to the control register take effect
			next_dp_write = hwrite && (hsize == FPX_HSIZE_WORD) &&
				(addr_low == FPX_CTRL_OFFSET);
			if (!hwrite)
			begin
				next_hrdata = 32'h0000_0000;
				case (addr_low)
					FPX_CTRL_OFFSET:
					begin
						next_hrdata[FPX_CTRL_ROUND_LSB +: 2] = round_mode;
						next_hrdata[FPX_CTRL_IEEE_BIT] = ieee_mode;
					end
					FPX_RESULT_OFFSET:
						next_hrdata = unload.value;
					FPX_STATUS_OFFSET:
					begin
						next_hrdata[FPX_STAT_CODE_LSB +: 3] = unload.code;
						next_hrdata[FPX_STAT_VALID_BIT] = result_valid;
					end
					default:
						next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			round_mode <= fpx_round_t'(FPX_ROUND_RESET);
			ieee_mode <= FPX_IEEE_RESET;
			dp_write <= 1'b0;
			hrdata <= 32'h0000_0000;
		end
		else
		begin
			round_mode <= next_round_mode;
			ieee_mode <= next_ieee_mode;
			dp_write <= next_dp_write;
			hrdata <= next_hrdata;
		end
	end

	// Exception detection on the rounded result
	assign overflow_flag = op.exp > FPX_EXP_MAX;
	assign underflow_flag = (op.exp < FPX_EXP_MIN) ||
		op.denormalize_instruction;
	assign inexact_flag = |op.discard;
	assign plain_value = {op.sign, op.exp[7:0], op.frac};
	assign signed_zero = {op.sign, 31'h0000_0000};

	// Checks are ordered so that one combined code results
	always_comb
	begin
		next_result_valid = op_valid;
		next_unload = unload;
		if (op_valid)
		begin
			next_unload.value = plain_value;
			next_unload.code = inexact_flag ? FPX_CODE_INEXACT :
				FPX_CODE_NONE;
			if (op.denorm_in && ieee_mode && !op.alu_op)
			begin
				// Operand must be normalized by the controller first
				next_unload.code = FPX_CODE_DIN;
				next_unload.value = 32'h0000_0000;
			end
			else if (op.invalid)
			begin
				next_unload.code = FPX_CODE_BAD_OP;
				next_unload.value = FPX_QNAN;
			end
			else if (overflow_flag)
			begin
				next_unload.code = FPX_CODE_OVER_INEXACT;
				// Toward zero saturates, so overflow sticks at the largest value
				case (round_mode)
					round_nearest:
						next_unload.value = op.sign ? FPX_NEG_INF :
							FPX_POS_INF;
					round_toward_zero:
						next_unload.value = op.sign ? FPX_NEG_MAX :
							FPX_POS_MAX;
					round_toward_plus:
						next_unload.value = op.sign ? FPX_NEG_MAX :
							FPX_POS_INF;
					round_toward_minus:
						next_unload.value = op.sign ? FPX_NEG_INF :
							FPX_POS_MAX;
					default:
						next_unload.value = FPX_QNAN;
				endcase
			end
			else if (underflow_flag)
			begin
				if (op.alu_op)
				begin
					next_unload.code = FPX_CODE_UNDER_INEXACT;
					next_unload.value = ieee_mode ?
						{op.sign, 8'h00, op.frac} : signed_zero;
				end
				else
				begin
					next_unload.code = inexact_flag ? FPX_CODE_UNDER_INEXACT :
						FPX_CODE_UNDER;
					if (op.denormalize_instruction)
						next_unload.value = {op.sign, 8'h00, op.frac};
					else if (ieee_mode)
						// Wrapped exponent, left for the denormalize step
						next_unload.value = plain_value;
					else
						next_unload.value = signed_zero;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			result_valid <= 1'b0;
			unload <= '0;
		end
		else
		begin
			result_valid <= next_result_valid;
			unload <= next_unload;
		end
	end

	default clocking chk_clk @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic in_range;
	logic clean;
	assign in_range = (op.exp >= FPX_EXP_MIN) && (op.exp <= FPX_EXP_MAX) &&
		!op.denormalize_instruction;
	assign clean = op_valid && !op.invalid &&
		!(op.denorm_in && ieee_mode && !op.alu_op);

	// Each check from chk_inexact_code to chk_denorm_zero looks one edge after op_valid, at the registered unload
	chk_inexact_code: assert property (
		clean && in_range |=> unload.code == {2'b00, $past(inexact_flag)})
		else $error("inexact code wrong for in-range result");

	chk_mult_underflow: assert property (
		clean && !op.alu_op && (op.exp < FPX_EXP_MIN)
		|=> unload.code[2:1] == 2'b01)
		else $error("multiplier underflow not reported");

	chk_ieee_unnormalized: assert property (
		clean && ieee_mode && !op.alu_op && (op.exp < FPX_EXP_MIN) &&
		!op.denormalize_instruction
		|=> unload.value[30:23] == $past(op.exp[7:0]))
		else $error("unnormalized result not passed through");

	chk_fast_zero: assert property (
		clean && !ieee_mode && !op.alu_op && (op.exp < FPX_EXP_MIN) &&
		!op.denormalize_instruction
		|=> unload.value[30:0] == 31'h0000_0000)
		else $error("fast underflow result not zero");

	chk_alu_underflow: assert property (
		clean && op.alu_op && underflow_flag && !overflow_flag
		|=> unload.code == FPX_CODE_UNDER_INEXACT)
		else $error("ALU underflow code wrong");

	chk_overflow_code: assert property (
		clean && overflow_flag
		|=> unload.code == FPX_CODE_OVER_INEXACT && result_valid)
		else $error("overflow code wrong");

	chk_nearest_inf: assert property (
		clean && overflow_flag && round_mode == round_nearest
		|=> unload.value == ($past(op.sign) ? FPX_NEG_INF : FPX_POS_INF))
		else $error("round-nearest overflow value wrong");

	chk_directed_ovf: assert property (
		clean && overflow_flag && round_mode == round_toward_plus && op.sign
		|=> unload.value == FPX_NEG_MAX)
		else $error("toward-plus negative overflow wrong");

	chk_plus_inf: assert property (
		clean && overflow_flag && round_mode == round_toward_plus && !op.sign
		|=> unload.value == FPX_POS_INF)
		else $error("toward-plus positive overflow wrong");

	chk_minus_ovf: assert property (
		clean && overflow_flag && round_mode == round_toward_minus && !op.sign
		|=> unload.value == FPX_POS_MAX)
		else $error("toward-minus positive overflow wrong");

	chk_zero_max: assert property (
		clean && overflow_flag && round_mode == round_toward_zero
		|=> unload.value ==
		($past(op.sign) ? FPX_NEG_MAX : FPX_POS_MAX))
		else $error("toward-zero overflow value wrong");

	chk_invalid_nan: assert property (
		op_valid && op.invalid && !(op.denorm_in && ieee_mode && !op.alu_op)
		|=> unload.code == FPX_CODE_BAD_OP && unload.value == FPX_QNAN)
		else $error("invalid operation not flagged");

	chk_denorm_zero: assert property (
		op_valid && op.denorm_in && ieee_mode && !op.alu_op
		|=> unload.code == FPX_CODE_DIN && unload.value == 32'h0000_0000)
		else $error("denormal input not flagged with zero");

	chk_unload_pair: assert property (
		result_valid |-> $past(op_valid) && unload.code != 3'h4)
		else $error("status without matching operation");

	chk_unload_hold: assert property (
		!op_valid |=> $stable(unload) && !result_valid)
		else $error("unload changed without an operation");

	chk_ctrl_write: assert property (
		dp_write |=> round_mode == $past(hwdata[FPX_CTRL_ROUND_LSB +: 2]) &&
		ieee_mode == $past(hwdata[FPX_CTRL_IEEE_BIT]))
		else $error("control write not taken");

	cov_overflow: cover property (clean && overflow_flag ##1 result_valid);
	cov_fast_underflow: cover property (
		clean && !ieee_mode && !op.alu_op && (op.exp < FPX_EXP_MIN));
	cov_denorm_input: cover property (
		op_valid && op.denorm_in && ieee_mode && !op.alu_op);
	cov_ctrl_write: cover property (dp_write);
	cov_back_to_back: cover property (op_valid ##1 op_valid);

endmodule // fpx_exception_status

// ===== core/fpx_pkg.sv
package fpx_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [3:0] FPX_CTRL_OFFSET = 4'h0;
	localparam logic [3:0] FPX_RESULT_OFFSET = 4'h4;
	localparam logic [3:0] FPX_STATUS_OFFSET = 4'h8;

	// Control register fields
	localparam int FPX_CTRL_ROUND_LSB = 0;
	localparam int FPX_CTRL_IEEE_BIT = 2;
	localparam logic [1:0] FPX_ROUND_RESET = 2'h0;
	localparam logic FPX_IEEE_RESET = 1'b1;

	// Status register fields
	localparam int FPX_STAT_CODE_LSB = 0;
	localparam int FPX_STAT_VALID_BIT = 3;

	// AHB constants
	localparam logic [2:0] FPX_HSIZE_WORD = 3'h2;
	localparam logic FPX_HRESP_OKAY = 1'b0;

	// Three-bit exception codes
	localparam logic [2:0] FPX_CODE_NONE = 3'h0;
	localparam logic [2:0] FPX_CODE_INEXACT = 3'h1;
	localparam logic [2:0] FPX_CODE_UNDER = 3'h2;
	localparam logic [2:0] FPX_CODE_UNDER_INEXACT = 3'h3;
	localparam logic [2:0] FPX_CODE_OVER_INEXACT = 3'h5;
	localparam logic [2:0] FPX_CODE_BAD_OP = 3'h6;
	localparam logic [2:0] FPX_CODE_DIN = 3'h7;

	// Substituted results
	localparam logic [31:0] FPX_POS_INF = 32'h7F80_0000;
	localparam logic [31:0] FPX_NEG_INF = 32'hFF80_0000;
	localparam logic [31:0] FPX_POS_MAX = 32'h7F7F_FFFF;
	localparam logic [31:0] FPX_NEG_MAX = 32'hFF7F_FFFF;
	localparam logic [31:0] FPX_QNAN = 32'h7FC0_0000;

	// Biased exponent limits of the normalized range
	localparam logic signed [9:0] FPX_EXP_MAX = 10'sh0FE;
	localparam logic signed [9:0] FPX_EXP_MIN = 10'sh001;

	typedef enum logic [1:0]
	{
		round_nearest = 2'h0,
		round_toward_zero = 2'h1,
		round_toward_plus = 2'h2,
		round_toward_minus = 2'h3
	} fpx_round_t;

	// Rounded result handed over by the arithmetic datapath
	typedef struct packed
	{
		logic alu_op;
		logic denormalize_instruction;
		logic sign;
		logic signed [9:0] exp;
		logic [22:0] frac;
		logic [7:0] discard;
		logic invalid;
		logic denorm_in;
	} fpx_op_t;

	// Result and status unloaded together
	typedef struct packed
	{
		logic [31:0] value;
		logic [2:0] code;
	} fpx_unload_t;

endpackage

// ===== test/fpx_seq_model.sv
`timescale 1ns/10ps
module fpx_seq_model
	import fpx_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Requests from the bench
	input wire logic issue,
	input wire fpx_op_t issue_op,
	// Datapath side
	output logic op_valid,
	output fpx_op_t op,
	input wire logic result_valid,
	input wire fpx_unload_t unload
);
	fpx_op_t last_op;
	fpx_op_t retry_op;
	// The retried operand comes back normalized
	always_comb
	begin
		retry_op = last_op;
		retry_op.denorm_in = 1'b0;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			op_valid <= 1'b0;
			op <= '0;
			last_op <= '0;
		end
		else if (issue)
		begin
			op_valid <= 1'b1;
			op <= issue_op;
			last_op <= issue_op;
		end
		else if (result_valid && unload.code == FPX_CODE_DIN)
		begin
			// Operand normalized, then the multiply is retried
			op_valid <= 1'b1;
			op <= retry_op;
		end
		else
		begin
			// Idle bus alternates each cycle between the inverted and the last operand
			op_valid <= 1'b0;
			op <= ~op;
		end
	end
endmodule // fpx_seq_model

// ===== test/tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) \
	begin \
		checks_done++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("Error %0t: got %h expected %h", $time, g, e); \
		end \
	end
module tb_top;
	import fpx_pkg::*;
	typedef struct packed
	{
		logic [2:0] ctrl;
		fpx_op_t op;
		logic [31:0] val;
		logic [2:0] code;
	} fpx_row_t;
	localparam logic [22:0] frac_pat = 23'h2A_5A5A;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = FPX_HSIZE_WORD;
	logic [31:0] hwdata = 32'h0;
	logic issue = 1'b0;
	fpx_op_t issue_op = '0;
	logic hready, hresp, op_valid, result_valid;
	logic [31:0] hrdata, rd;
	fpx_op_t op;
	fpx_unload_t unload;
	fpx_row_t rows[$];
	int miscompares = 0;
	int checks_done = 0;

	always #12.5 hclk = ~hclk;

	fpx_exception_status u_fpx_exception_status (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.op_valid(op_valid), .op(op), .result_valid(result_valid),
		.unload(unload));
	fpx_seq_model u_fpx_seq_model (.hclk(hclk), .hresetn(hresetn),
		.issue(issue), .issue_op(issue_op), .op_valid(op_valid), .op(op),
		.result_valid(result_valid), .unload(unload));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Zero wait states are expected, but a hang must still end the run
	task automatic wait_for(input int sel);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while ((sel ? result_valid : hready) !== 1'b1 && n < 20);
		if ((sel ? result_valid : hready) !== 1'b1)
		begin
			miscompares++;
			$display("Error %0t: wait timed out", $time);
			end_sim;
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_for(0);
		htrans <= 2'h0;
		hwdata <= d;
		wait_for(0);
		q = hrdata;
		`CHK(hresp, FPX_HRESP_OKAY)
	endtask

	task automatic do_op(input fpx_op_t o);
		issue <= 1'b1;
		issue_op <= o;
		@(posedge hclk);
		issue <= 1'b0;
		wait_for(1);
	endtask

	task automatic r(input logic [2:0] c, input logic a, dn, s,
		input logic signed [9:0] e, input logic [7:0] d, input logic iv, dm,
		input logic [31:0] v, input logic [2:0] k);
		rows.push_back(fpx_row_t'{c, '{a, dn, s, e, frac_pat, d, iv, dm}, v, k});
	endtask

	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(result_valid, 1'b0)
		`CHK(unload, fpx_unload_t'('0))
		ahb(0, 32'h0, 32'h0, rd);
		`CHK(rd, 32'h0000_0004)
		ahb(0, 32'hC, 32'h0, rd);
		`CHK(rd, 32'h0)
		ahb(1, 32'h4, 32'hFFFF_FFFF, rd);
		ahb(0, 32'h4, 32'h0, rd);
		`CHK(rd, 32'h0)
		$display("reset and map test done");
		r(3'h4,0,0,0,10'sh0FF,8'h00,0,0,32'h7F80_0000,3'h5);
		r(3'h4,1,0,1,10'sh0FF,8'h00,0,0,32'hFF80_0000,3'h5);
		r(3'h5,0,0,0,10'sh0FF,8'h00,0,0,32'h7F7F_FFFF,3'h5);
		r(3'h5,0,0,1,10'sh0FF,8'h00,0,0,32'hFF7F_FFFF,3'h5);
		r(3'h6,0,0,0,10'sh0FF,8'h00,0,0,32'h7F80_0000,3'h5);
		r(3'h6,0,0,1,10'sh0FF,8'h00,0,0,32'hFF7F_FFFF,3'h5);
		r(3'h7,0,0,0,10'sh0FF,8'h00,0,0,32'h7F7F_FFFF,3'h5);
		r(3'h3,1,0,1,10'sh0FF,8'h00,0,0,32'hFF80_0000,3'h5);
		r(3'h4,0,0,0,10'sh064,8'h01,0,0,{1'b0,8'h64,frac_pat},3'h1);
		r(3'h4,0,0,1,10'sh0FE,8'h00,0,0,{1'b1,8'hFE,frac_pat},3'h0);
		r(3'h4,0,0,0,10'sh001,8'h80,0,0,{1'b0,8'h01,frac_pat},3'h1);
		r(3'h4,0,0,1,10'sh3FD,8'h00,0,0,{1'b1,8'hFD,frac_pat},3'h2);
		r(3'h4,0,0,0,10'sh000,8'h80,0,0,{1'b0,8'h00,frac_pat},3'h3);
		r(3'h4,0,1,1,10'sh064,8'h01,0,0,{1'b1,8'h00,frac_pat},3'h3);
		r(3'h0,0,0,1,10'sh3FD,8'h00,0,0,32'h8000_0000,3'h2);
		r(3'h1,0,0,0,10'sh000,8'h10,0,0,32'h0000_0000,3'h3);
		r(3'h4,1,0,1,10'sh000,8'h00,0,0,{1'b1,8'h00,frac_pat},3'h3);
		r(3'h2,1,0,0,10'sh3FD,8'h00,0,0,32'h0000_0000,3'h3);
		r(3'h4,0,0,1,10'sh0FF,8'hFF,1,0,32'h7FC0_0000,3'h6);
		r(3'h4,1,0,0,10'sh064,8'h00,0,1,{1'b0,8'h64,frac_pat},3'h0);
		r(3'h0,0,0,0,10'sh064,8'h02,0,1,{1'b0,8'h64,frac_pat},3'h1);
		foreach (rows[i])
		begin
			ahb(1, 32'h0, {29'h0, rows[i].ctrl}, rd);
			do_op(rows[i].op);
			`CHK(unload.value, rows[i].val)
			`CHK(unload.code, rows[i].code)
			ahb(0, 32'h8, 32'h0, rd);
			`CHK(rd, {29'h0, rows[i].code})
			ahb(0, 32'h4, 32'h0, rd);
			`CHK(rd, rows[i].val)
		end
		$display("table test done");
		ahb(1, 32'h0, 32'h0000_0004, rd);
		do_op('{1'b0, 1'b0, 1'b1, 10'sh064, frac_pat, 8'h00, 1'b0, 1'b1});
		`CHK(unload.code, FPX_CODE_DIN)
		`CHK(unload.value, 32'h0000_0000)
		wait_for(1);
		`CHK(unload.code, FPX_CODE_NONE)
		`CHK(unload.value, {1'b1, 8'h64, frac_pat})
		$display("denormal input test done");
		issue <= 1'b1;
		issue_op <= '{1'b0, 1'b0, 1'b0, 10'sh0FF, frac_pat, 8'h00, 1'b0, 1'b0};
		@(posedge hclk);
		issue_op <= '{1'b0, 1'b0, 1'b0, 10'sh064, frac_pat, 8'h01, 1'b0, 1'b0};
		@(posedge hclk);
		issue <= 1'b0;
		wait_for(1);
		`CHK(unload.code, FPX_CODE_OVER_INEXACT)
		@(posedge hclk);
		`CHK(result_valid, 1'b1)
		`CHK(unload.code, FPX_CODE_INEXACT)
		$display("back to back test done");
		ahb(1, 32'h0, 32'h0000_0003, rd);
		hresetn <= 1'b0;
		@(posedge hclk);
		`CHK(unload, fpx_unload_t'('0))
		`CHK(hrdata, 32'h0000_0000)
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(result_valid, 1'b0)
		ahb(0, 32'h0, 32'h0, rd);
		`CHK(rd, 32'h0000_0004)
		do_op('{1'b0, 1'b0, 1'b0, 10'sh0FF, frac_pat, 8'h00, 1'b0, 1'b0});
		`CHK(unload.value, FPX_POS_INF)
		$display("mid-run reset test done");
		end_sim;
	end
endmodule // tb_top
